// [shared/cc0_pkg.sv]
// package for the control register zero block: offsets, fields, resets
// assumes a 32-bit AXI4-Lite register bus, one word per register
package cc0_pkg;
  // byte addresses
  localparam logic [7:0] CC0_OFF_CTL0  = 8'h00;
  localparam logic [7:0] CC0_OFF_CTL1  = 8'h04;
  localparam logic [7:0] CC0_OFF_TSTMP = 8'h08;
  localparam logic [7:0] CC0_OFF_IRQST = 8'h0C;
  localparam logic [7:0] CC0_OFF_IRQMK = 8'h10;
  // control register zero fields
  localparam int CC0_B_RECEIVED_FRAME_FLAG = 7;
  localparam int CC0_B_RECEIVER_ACTIVE_STATUS = 6;
  localparam int CC0_B_SWAIT = 5;
  localparam int CC0_B_SYNC  = 4;
  localparam int CC0_B_TIMER = 3;
  localparam int CC0_B_WAKEUP_ENABLE  = 2;
  localparam int CC0_B_SLEEP_REQUEST = 1;
  localparam int CC0_B_INIRQ = 0;
  // control register one fields
  localparam int CC0_B_LOOPB = 5;
  localparam int CC0_B_INIAK = 0;
  localparam logic [7:0] CC0_CTL0_RST = 8'h01;
  // interrupt status bits
  localparam int CC0_I_RECEIVED_FRAME_FLAG = 0;
  localparam int CC0_I_SYNC  = 1;
  localparam int CC0_IRQ_W   = 2;
  localparam logic [1:0] CC0_RESP_OK  = 2'h0;
  localparam logic [1:0] CC0_RESP_ERR = 2'h2;
  // cycles spent in CC0_WAIT before an init request is acknowledged
  localparam int CC0_INIT_ACK_CYC = 2;
  typedef enum logic [1:0] {
    CC0_RUN  = 2'b00,
    CC0_WAIT = 2'b01,
    CC0_INIT = 2'b11
  } cc0_mode_t;
endpackage : cc0_pkg

// [src/cc0_sync3.sv]
// three-flop synchroniser for one pin level
// assumes the input is asynchronous to CLOCK
`timescale 1ns/100ps
module cc0_sync3
  import cc0_pkg::*;
(
  input  wire logic CLOCK,
  input  wire logic SRST,
  input  wire logic din,
  output logic      dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change counts once second and third agree
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule : cc0_sync3

// [src/cc0_tstamp.sv]
// free-running 16-bit time-stamp counter on the bit clock tick
// assumes bit_tick is a one-cycle pulse on CLOCK
`timescale 1ns/100ps
module cc0_tstamp
  import cc0_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        enable,
  input  wire logic        bit_tick,
  output logic [15:0]      count
);
  always_ff @(posedge CLOCK) begin
    if (SRST || !enable) begin
      count <= 16'h0000;
    end else if (bit_tick) begin
      count <= count + 16'h0001;
    end
  end
endmodule : cc0_tstamp

// [src/cc0_ctrl_zero.sv]
// control register zero of a CAN controller, with AXI4-Lite slave
// assumes the CAN engine supplies status pins and pulses on CLOCK
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// Function
// - every register bit is read from clocked flops on CLOCK, except the loopback bit, read straight from LOOPBACK.
// - writes are taken outside init; status bits are read-only.
// - in init mode all bits but wake, sleep and init hold reset.
// - writes work again once init request and acknowledge are low.
// - bit 7 is set on each valid received message until cleared.
// - writing one to bit 7 clears it; writing zero is ignored.
// - bits 7 and 6 are undefined while loopback is active.
// - bit 6 shows the receive front end is receiving a message.
// - bit 5 set gates off bus-side clocks in wait mode.
// - bit 4 reads one when synchronized to the bus and no init is requested.
// - bit 3 starts a 16-bit counter advanced by the bit clock.
// - at end of a valid frame the count is written to the buffer.
// - a disabled timer reads zero; bit 3 is low in init mode.
// - an init request is acknowledged and drops bus activity.
module cc0_ctrl_zero
  import cc0_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  // AXI4-Lite slave
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // CAN engine side
  input  wire logic        RX_FRAME_OK,
  input  wire logic        RX_BUSY_PIN,
  input  wire logic        BUS_SYNCED,
  input  wire logic        BIT_TICK,
  input  wire logic        EOF_VALID,
  input  wire logic        LOOPBACK,
  input  wire logic        CPU_WAIT,
  output logic             INIT_ACKNOWLEDGE,
  output logic             ABORT_XFER,
  output logic             BUS_CLK_GATE,
  output logic             STAMP_WE,
  output logic [15:0]      STAMP_DATA,
  output logic             IRQ
);
  logic [7:0]           ctl0_q;
  logic                 init_ack_q;
  logic [1:0]           ack_cnt_q;
  cc0_mode_t            mode_q;
  logic [CC0_IRQ_W-1:0] ist_q;
  logic [CC0_IRQ_W-1:0] imsk_q;
  logic                 sync_prev_q;
  logic                 rx_act;
  logic                 sync_ok;
  logic [15:0]          tcount;
  logic                 aw_got_q;
  logic                 w_got_q;
  logic [7:0]           awaddr_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 do_wr;
  logic                 in_init;
  logic                 wr_ctl0;
  logic                 wr_ist;
  logic [CC0_IRQ_W-1:0] ist_set;
  logic [CC0_IRQ_W-1:0] ist_clr;
  logic                 wr_imsk;
  logic                 aw_map;
  logic [31:0]          rd_word;
  logic                 rd_err;

  assign in_init = ctl0_q[CC0_B_INIRQ] && init_ack_q;
  assign sync_ok = BUS_SYNCED && !ctl0_q[CC0_B_INIRQ];

  // receive busy comes from an outside pin
  cc0_sync3 u_rx_sync (
    .CLOCK (CLOCK),
    .SRST  (SRST),
    .din   (RX_BUSY_PIN),
    .dout  (rx_act)
  );

  cc0_tstamp u_tstamp (
    .CLOCK    (CLOCK),
    .SRST     (SRST),
    .enable   (ctl0_q[CC0_B_TIMER]),
    .bit_tick (BIT_TICK),
    .count    (tcount)
  );

  // write channel capture, address and data in either order
  assign do_wr = aw_got_q && w_got_q && !BVALID;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      aw_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      AWREADY  <= 1'b0;
    end else if (do_wr) begin
      aw_got_q <= 1'b0;
      AWREADY  <= 1'b0;
    end else if (AWVALID && AWREADY) begin
      aw_got_q <= 1'b1;
      awaddr_q <= AWADDR;
      AWREADY  <= 1'b0;
    end else begin
      // readies reopen only after the response is taken
      AWREADY  <= !aw_got_q && !BVALID;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      w_got_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      WREADY  <= 1'b0;
    end else if (do_wr) begin
      w_got_q <= 1'b0;
      WREADY  <= 1'b0;
    end else if (WVALID && WREADY) begin
      w_got_q <= 1'b1;
      wdata_q <= WDATA;
      wstrb_q <= WSTRB;
      WREADY  <= 1'b0;
    end else begin
      WREADY  <= !w_got_q && !BVALID;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      BVALID <= 1'b0;
      BRESP  <= CC0_RESP_OK;
    end else if (do_wr) begin
      BVALID <= 1'b1;
      BRESP  <= aw_map ? CC0_RESP_OK : CC0_RESP_ERR;
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end

  assign wr_ctl0 = do_wr && awaddr_q == CC0_OFF_CTL0 && wstrb_q[0];
  assign wr_ist  = do_wr && awaddr_q == CC0_OFF_IRQST && wstrb_q[0];
  assign wr_imsk = do_wr && awaddr_q == CC0_OFF_IRQMK && wstrb_q[0];

  // unmapped word offsets answer with a slave error, data dropped
  always_comb begin
    case (awaddr_q)
      CC0_OFF_CTL0, CC0_OFF_CTL1, CC0_OFF_TSTMP,
      CC0_OFF_IRQST, CC0_OFF_IRQMK: aw_map = 1'b1;
      default:                      aw_map = 1'b0;
    endcase
  end

  // control register zero
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ctl0_q <= CC0_CTL0_RST;
    end else begin
      // status bits follow hardware, always readable
      ctl0_q[CC0_B_RECEIVER_ACTIVE_STATUS] <= rx_act && !in_init;
      ctl0_q[CC0_B_SYNC]  <= sync_ok && !in_init;
      if (in_init) begin
        ctl0_q[CC0_B_RECEIVED_FRAME_FLAG] <= 1'b0;
        ctl0_q[CC0_B_SWAIT] <= 1'b0;
        ctl0_q[CC0_B_TIMER] <= 1'b0;
        if (wr_ctl0) begin
          ctl0_q[CC0_B_WAKEUP_ENABLE]  <= wdata_q[CC0_B_WAKEUP_ENABLE];
          ctl0_q[CC0_B_SLEEP_REQUEST] <= wdata_q[CC0_B_SLEEP_REQUEST];
          ctl0_q[CC0_B_INIRQ] <= wdata_q[CC0_B_INIRQ];
        end
      end else begin
        // set wins over a clear in the same cycle
        if (RX_FRAME_OK) begin
          ctl0_q[CC0_B_RECEIVED_FRAME_FLAG] <= 1'b1;
        end else if (wr_ctl0 && wdata_q[CC0_B_RECEIVED_FRAME_FLAG]) begin
          ctl0_q[CC0_B_RECEIVED_FRAME_FLAG] <= 1'b0;
        end
        // writable only while the init acknowledge is low
        if (wr_ctl0 && !init_ack_q) begin
          ctl0_q[CC0_B_SWAIT] <= wdata_q[CC0_B_SWAIT];
          ctl0_q[CC0_B_TIMER] <= wdata_q[CC0_B_TIMER];
          ctl0_q[CC0_B_WAKEUP_ENABLE]  <= wdata_q[CC0_B_WAKEUP_ENABLE];
          ctl0_q[CC0_B_SLEEP_REQUEST] <= wdata_q[CC0_B_SLEEP_REQUEST];
          ctl0_q[CC0_B_INIRQ] <= wdata_q[CC0_B_INIRQ];
        end
        if (ctl0_q[CC0_B_INIRQ]) begin
          ctl0_q[CC0_B_TIMER] <= 1'b0;
        end
      end
    end
  end

  // init handshake: acknowledge after a short abort window
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      mode_q     <= CC0_INIT;
      init_ack_q <= 1'b1;
      ack_cnt_q  <= 2'h0;
      ABORT_XFER <= 1'b1;
    end else begin
      case (mode_q)
        CC0_RUN: begin
          if (ctl0_q[CC0_B_INIRQ]) begin
            mode_q     <= CC0_WAIT;
            ack_cnt_q  <= 2'h0;
            ABORT_XFER <= 1'b1;
          end
        end
        CC0_WAIT: begin
          if (!ctl0_q[CC0_B_INIRQ]) begin
            mode_q     <= CC0_RUN;
            ABORT_XFER <= 1'b0;
          end else if (ack_cnt_q == 2'(CC0_INIT_ACK_CYC - 1)) begin
            mode_q     <= CC0_INIT;
            init_ack_q <= 1'b1;
          end else begin
            ack_cnt_q <= ack_cnt_q + 2'h1;
          end
        end
        CC0_INIT: begin
          // leaving init: the engine resyncs once abort drops
          if (!ctl0_q[CC0_B_INIRQ]) begin
            mode_q     <= CC0_RUN;
            init_ack_q <= 1'b0;
            ABORT_XFER <= 1'b0;
          end
        end
        default: begin
          mode_q <= CC0_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      INIT_ACKNOWLEDGE <= 1'b1;
      BUS_CLK_GATE     <= 1'b0;
    end else begin
      INIT_ACKNOWLEDGE <= init_ack_q;
      BUS_CLK_GATE     <= ctl0_q[CC0_B_SWAIT] && CPU_WAIT;
    end
  end

  // stamp the buffer's two top bytes right after a valid end of frame
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      STAMP_WE   <= 1'b0;
      STAMP_DATA <= 16'h0000;
    end else begin
      STAMP_WE   <= EOF_VALID && ctl0_q[CC0_B_TIMER];
      STAMP_DATA <= tcount;
    end
  end

  // interrupt status: received frame and sync gained
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sync_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= ctl0_q[CC0_B_SYNC];
    end
  end

  always_comb begin
    ist_set = '0;
    ist_set[CC0_I_RECEIVED_FRAME_FLAG] = RX_FRAME_OK && !in_init && !LOOPBACK;
    ist_set[CC0_I_SYNC]  = ctl0_q[CC0_B_SYNC] && !sync_prev_q;
    ist_clr = wr_ist ? wdata_q[CC0_IRQ_W-1:0] : '0;
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ist_q  <= '0;
      imsk_q <= '0;
      IRQ    <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~ist_clr) | ist_set;
      if (wr_imsk) begin
        imsk_q <= wdata_q[CC0_IRQ_W-1:0];
      end
      IRQ <= |(((ist_q & ~ist_clr) | ist_set) & imsk_q);
    end
  end

  // read word select; fields are flops on CLOCK except the loopback bit, read straight from LOOPBACK
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    case (ARADDR)
      CC0_OFF_CTL0: begin
        rd_word[7:0] = ctl0_q;
      end
      CC0_OFF_CTL1: begin
        rd_word[CC0_B_INIAK] = init_ack_q;
        rd_word[CC0_B_LOOPB] = LOOPBACK;
      end
      CC0_OFF_TSTMP: begin
        rd_word[15:0] = tcount;
      end
      CC0_OFF_IRQST: begin
        rd_word[CC0_IRQ_W-1:0] = ist_q;
      end
      CC0_OFF_IRQMK: begin
        rd_word[CC0_IRQ_W-1:0] = imsk_q;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= CC0_RESP_OK;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_word;
      RRESP   <= rd_err ? CC0_RESP_ERR : CC0_RESP_OK;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end else begin
      ARREADY <= !RVALID;
    end
  end
endmodule : cc0_ctrl_zero

// [dv/cc0_can_node.sv]
// model of the CAN engine and bus traffic feeding the block
// assumes one CLOCK domain; a start pulse brings one received frame
`timescale 1ns/100ps
module cc0_can_node (
  input  wire logic CLOCK,
  input  wire logic SRST,
  input  wire logic start,
  input  wire logic abort,
  input  wire logic fast,
  output logic      rx_ok,
  output logic      rx_busy,
  output logic      eof,
  output logic      tick,
  output logic      synced
);
  logic [3:0] cnt_q;
  logic [1:0] div_q;
  always_ff @(posedge CLOCK) begin
    div_q  <= SRST ? 2'h0 : div_q + 2'h1;
    tick   <= !SRST && (fast || div_q == 2'h3);
    synced <= !SRST && !abort;
  end
  always_ff @(posedge CLOCK) begin
    if (SRST || abort) cnt_q <= 4'h0;
    else if (start) cnt_q <= 4'hC;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    rx_busy <= (cnt_q > 4'h1);
    eof     <= (cnt_q == 4'h1);
    rx_ok   <= (cnt_q == 4'h1);
  end
endmodule : cc0_can_node

// [dv/cc0_ctrl_zero_properties.sv]
// checker for the control register zero block: bus and engine relations
// assumes binding into cc0_ctrl_zero, single CLOCK domain
`timescale 1ns/100ps
module cc0_ctrl_zero_properties (
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic        CPU_WAIT,
  input wire logic        BUS_CLK_GATE,
  input wire logic        EOF_VALID,
  input wire logic        STAMP_WE,
  input wire logic [15:0] STAMP_DATA,
  input wire logic        INIT_ACKNOWLEDGE,
  input wire logic        ABORT_XFER,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read not answered next cycle");
  a_read_hold: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data not held");
  a_write_answer: assert property (
    AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write not answered two cycles after both were taken");
  a_write_hold: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped");
  a_gate_wait: assert property (!CPU_WAIT |=> !BUS_CLK_GATE)
    else $error("clock gated outside wait");
  a_stamp_eof: assert property (STAMP_WE |-> $past(EOF_VALID))
    else $error("stamp write without end of frame");
  a_count_step: assert property (
    $changed(STAMP_DATA) && STAMP_DATA != 16'h0
    |-> STAMP_DATA == $past(STAMP_DATA) + 16'h1)
    else $error("counter did not step by one");
  a_count_wrap: assert property (
    $past(STAMP_DATA) == 16'hFFFF && $changed(STAMP_DATA)
    |-> STAMP_DATA == 16'h0)
    else $error("counter did not wrap to zero");
  a_ack_abort: assert property ($rose(INIT_ACKNOWLEDGE) |-> ABORT_XFER)
    else $error("init acknowledged without abort");
  c_stamp: cover property (STAMP_WE);
  c_irq: cover property ($rose(IRQ));
  c_gate: cover property (BUS_CLK_GATE);
endmodule : cc0_ctrl_zero_properties
bind cc0_ctrl_zero cc0_ctrl_zero_properties u_props (
  .CLOCK(CLOCK), .SRST(SRST), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
  .RREADY(RREADY), .RDATA(RDATA), .CPU_WAIT(CPU_WAIT),
  .BUS_CLK_GATE(BUS_CLK_GATE), .EOF_VALID(EOF_VALID),
  .STAMP_WE(STAMP_WE), .STAMP_DATA(STAMP_DATA),
  .INIT_ACKNOWLEDGE(INIT_ACKNOWLEDGE), .ABORT_XFER(ABORT_XFER), .IRQ(IRQ));

// [dv/cc0_ctrl_zero_tb.sv]
// testbench for control register zero: AXI4-Lite register sequences
// assumes cc0_can_node stands in for the CAN engine
`timescale 1ns/100ps
module cc0_ctrl_zero_tb
  import cc0_pkg::*;
;
  logic        CLOCK, SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, start, irq_a;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [1:0]  BRESP, RRESP, r, b;
  logic        RX_FRAME_OK, RX_BUSY_PIN, BUS_SYNCED, BIT_TICK, EOF_VALID;
  logic        CPU_WAIT, INIT_ACKNOWLEDGE, ABORT_XFER, BUS_CLK_GATE;
  logic        STAMP_WE, IRQ, LOOPBACK, fast;
  logic [15:0] STAMP_DATA;
  int          num_errors, num_checks, n;
  always #10 CLOCK = !CLOCK;
  cc0_ctrl_zero uut (.CLOCK(CLOCK), .SRST(SRST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .RX_FRAME_OK(RX_FRAME_OK), .RX_BUSY_PIN(RX_BUSY_PIN),
    .BUS_SYNCED(BUS_SYNCED), .BIT_TICK(BIT_TICK), .EOF_VALID(EOF_VALID),
    .LOOPBACK(LOOPBACK), .CPU_WAIT(CPU_WAIT),
    .INIT_ACKNOWLEDGE(INIT_ACKNOWLEDGE), .ABORT_XFER(ABORT_XFER),
    .BUS_CLK_GATE(BUS_CLK_GATE), .STAMP_WE(STAMP_WE),
    .STAMP_DATA(STAMP_DATA), .IRQ(IRQ));
  cc0_can_node u_node (.CLOCK(CLOCK), .SRST(SRST), .start(start),
    .abort(ABORT_XFER), .rx_ok(RX_FRAME_OK), .rx_busy(RX_BUSY_PIN),
    .eof(EOF_VALID), .tick(BIT_TICK), .synced(BUS_SYNCED), .fast(fast));
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      k++;
    end while (BVALID !== 1'b1 && k < 50);
    b = BRESP;
    BREADY <= 1'b0;
    if (k >= 50) begin
      num_errors++;
      close_out();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 1'b0;
      k++;
    end while (RVALID !== 1'b1 && k < 50);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    if (k >= 50) begin
      num_errors++;
      close_out();
    end
  endtask : rd
  task automatic rck(input string nm, input logic [7:0] a,
                     input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(nm, e, d & m);
  endtask : rck
  initial begin
    {CLOCK, AWVALID, WVALID, BREADY, ARVALID, RREADY, start, fast} = '0;
    LOOPBACK = 1'b0;
    {AWADDR, ARADDR, WDATA, CPU_WAIT, num_errors, num_checks} = '0;
    SRST = 1'b1;
    repeat (16) @(posedge CLOCK);
    SRST <= 1'b0;
    rck("ctl0 reset", CC0_OFF_CTL0, 32'hFF, 32'h01);
    rck("init ack", CC0_OFF_CTL1, 32'h01, 32'h01);
    chk("abort", 32'h1, {31'h0, ABORT_XFER});
    chk("ack pin", 32'h1, {31'h0, INIT_ACKNOWLEDGE});
    wr(CC0_OFF_CTL0, 32'hFF);
    chk("bresp ok", {30'h0, CC0_RESP_OK}, {30'h0, b});
    rck("ctl0 in init", CC0_OFF_CTL0, 32'hFF, 32'h07);
    wr(CC0_OFF_CTL0, 32'h00);
    repeat (CC0_INIT_ACK_CYC + 8) @(posedge CLOCK);
    rck("ack low", CC0_OFF_CTL1, 32'h01, 32'h00);
    chk("ack pin low", 32'h0, {31'h0, INIT_ACKNOWLEDGE});
    LOOPBACK <= 1'b1;
    rck("loopback", CC0_OFF_CTL1, 32'h20, 32'h20);
    LOOPBACK <= 1'b0;
    wr(CC0_OFF_CTL0, 32'h78);
    rck("ctl0 run", CC0_OFF_CTL0, 32'hFF, 32'h38);
    CPU_WAIT <= 1'b1;
    repeat (3) @(posedge CLOCK);
    chk("clk gate", 32'h1, {31'h0, BUS_CLK_GATE});
    CPU_WAIT <= 1'b0;
    wr(CC0_OFF_IRQMK, 32'h0);
    start <= 1'b1;
    @(posedge CLOCK);
    start <= 1'b0;
    repeat (6) @(posedge CLOCK);
    rck("rx active", CC0_OFF_CTL0, 32'h40, 32'h40);
    n = 0;
    while (STAMP_WE !== 1'b1 && n < 40) begin
      @(posedge CLOCK);
      n++;
    end
    if (n >= 40) begin
      num_errors++;
      close_out();
    end
    chk("stamp", 32'h1, {31'h0, STAMP_DATA != 16'h0});
    repeat (8) @(posedge CLOCK);
    rck("rx frame", CC0_OFF_CTL0, 32'hFF, 32'hB8);
    rck("irq status", CC0_OFF_IRQST, 32'h01, 32'h01);
    irq_a = IRQ;
    wr(CC0_OFF_IRQMK, 32'h3);
    repeat (2) @(posedge CLOCK);
    chk("irq mask", 32'h1, {31'h0, irq_a ^ IRQ});
    wr(CC0_OFF_IRQST, 32'h3);
    repeat (2) @(posedge CLOCK);
    chk("irq clear", 32'h0, {31'h0, IRQ});
    wr(CC0_OFF_CTL0, 32'h28);
    rck("rx kept", CC0_OFF_CTL0, 32'h80, 32'h80);
    wr(CC0_OFF_CTL0, 32'hA8);
    rck("rx clear", CC0_OFF_CTL0, 32'h80, 32'h00);
    rd(CC0_OFF_TSTMP);
    chk("timer runs", 32'h1, {31'h0, d[15:0] != 16'h0});
    fast <= 1'b1;
    n = 0;
    while (STAMP_DATA !== 16'hFFFF && n < 70000) begin
      @(posedge CLOCK);
      n++;
    end
    if (n >= 70000) begin
      num_errors++;
      close_out();
    end
    @(posedge CLOCK);
    fast <= 1'b0;
    chk("wrap", 32'h0, {16'h0, STAMP_DATA});
    wr(CC0_OFF_CTL0, 32'h20);
    rck("timer off", CC0_OFF_TSTMP, 32'hFFFF, 32'h0);
    wr(CC0_OFF_CTL0, 32'h21);
    repeat (CC0_INIT_ACK_CYC + 8) @(posedge CLOCK);
    rck("init again", CC0_OFF_CTL0, 32'hFF, 32'h01);
    rd(8'h3C);
    chk("unmapped", {30'h0, CC0_RESP_ERR}, {30'h0, r});
    wr(8'h3C, 32'h0);
    chk("unmapped wr", {30'h0, CC0_RESP_ERR}, {30'h0, b});
    close_out();
  end
endmodule : cc0_ctrl_zero_tb
